/* File: pcx_regs.svh */
`ifndef PCX_REGS_SVH
`define PCX_REGS_SVH

// Byte offsets of the register words.
`define PCX_OFF_HLOG0      12'h11C
`define PCX_OFF_HLOG1      12'h120
`define PCX_OFF_HLOG2      12'h124
`define PCX_OFF_HLOG3      12'h128
`define PCX_OFF_SN_HDR     12'h148
`define PCX_OFF_SN_LOW     12'h14C
`define PCX_OFF_SN_HIGH    12'h150
`define PCX_OFF_PB_HDR     12'h158
`define PCX_OFF_PB_SEL     12'h15C
`define PCX_OFF_PB_DATA    12'h160
`define PCX_OFF_PB_CAP     12'h164
`define PCX_OFF_RID_HDR    12'h168
`define PCX_OFF_RID_CAP    12'h16C
`define PCX_OFF_RID_CTRL   12'h16E
`define PCX_OFF_SL_HDR     12'h178
`define PCX_OFF_LCTL3      12'h17C
`define PCX_OFF_LANE_ERR   12'h180
`define PCX_OFF_LEQ_FIRST  12'h184
`define PCX_OFF_LEQ_LAST   12'h18A
`define PCX_OFF_P16_HDR    12'h198
`define PCX_OFF_P16_CAP    12'h19C
`define PCX_OFF_P16_CTRL   12'h1A0
`define PCX_OFF_P16_STAT   12'h1A4
`define PCX_OFF_MG_HDR     12'h1BC
`define PCX_OFF_MG_PCAP    12'h1C0
`define PCX_OFF_MG_PSTAT   12'h1C2
`define PCX_OFF_MG_LCTRL   12'h1C4
`define PCX_OFF_MG_LSTAT   12'h1C6

// Capability header contents.
`define PCX_CAP_VER        4'h1
`define PCX_SN_ID          16'h0003
`define PCX_SN_NEXT        12'h158
`define PCX_POWER_BUDGET_CAP_HEADER          16'h0004
`define PCX_PB_NEXT        12'h168
`define PCX_RID_ID         16'h000E
`define PCX_RID_NEXT       12'h178
`define PCX_SL_ID          16'h0019
`define PCX_SL_NEXT        12'h198
`define PCX_P16_ID         16'h0026
`define PCX_P16_NEXT       12'h1BC
`define PCX_MG_ID          16'h0027
`define PCX_MG_NEXT        12'h224

// Lane equalization constants, reset values and status bit positions.
`define PCX_LEQ_RX_HINT    3'h7
`define PCX_LEQ_TX_PRESET  4'hF
`define PCX_PB_SYSALLOC_RST 1'h1
`define PCX_P16_EQREQ_BIT  4
`define PCX_MG_USAGE_BIT   6

`endif

/* File: pcx_pkg.sv */
package pcx_pkg;

  typedef logic [11:0] pcx_addr_t;
  typedef logic [31:0] pcx_word_t;

  typedef enum logic [1:0]
  {
    PCX_ACC_NONE  = 2'b00,
    PCX_ACC_WRITE = 2'b01,
    PCX_ACC_READ  = 2'b10
  } pcx_access_t;

endpackage : pcx_pkg

/* File: pcx_ext_cap_regs.sv */
// How it works
// - Serial number header: ID 3, ver 1, next 158h
// - Serial number: two read-only words, reset zero
// - Power budget header: ID 4, ver 1, next 168h
// - Selector bits 7:0 writable, upper bits zero
// - Power budget data fields read-only, reset zero
// - System-allocated bit 0 writable, resets to one
// - Routing-ID header: ID Eh, ver 1, next 178h
// - Routing control: group field, two enables writable
// - Routing capability reads all zero
// - Secondary link header: ID 19h, next 198h
// - Link control 3 hardwired to zero
// - Four writable lane error bits, reset zero
// - Lane equalization: hint 7h, preset Fh
// - Lane equalization downstream fields read zero
// - 16 GT/s header: ID 26h, next 1BCh
// - 16 GT/s status: writable request, read-only flags
// - 16 GT/s capability and control read zero
// - Margining header: ID 27h, next 224h
// - Margining driver-software flag writable, reset zero
// - Margining ready flags read-only, reset zero
// - Margining lane control fields writable, reset zero
// - Header log: sixteen read-only bytes, byte 0 top
`timescale 1ns/10ps
`include "pcx_regs.svh"

module pcx_ext_cap_regs
(
  // Clock and reset.
  input  wire logic                 i_clock,
  input  wire logic                 i_resetn,
  // Register port.
  input  wire pcx_pkg::pcx_addr_t   i_addr,
  input  wire pcx_pkg::pcx_word_t   i_wdata,
  input  wire logic                 i_write,
  input  wire logic                 i_read,
  output logic [31:0]               o_rdata,
  // Device state shown to software.
  input  wire logic [63:0]          i_serial_number,
  input  wire logic [20:0]          i_pb_data,
  input  wire logic [127:0]         i_header_log,
  input  wire logic [3:0]           i_lane_err_set,
  input  wire logic                 i_eq16_req_set,
  input  wire logic [3:0]           i_eq16_flags,
  input  wire logic [1:0]           i_margin_ready,
  input  wire logic [15:0]          i_margin_lane_status,
  // Settings steered by software.
  output logic [7:0]                o_pb_select,
  output logic                      o_pb_sys_alloc,
  output logic [2:0]                o_rid_func_group,
  output logic [1:0]                o_rid_group_en,
  output logic [3:0]                o_lane_err,
  output logic                      o_eq16_req,
  output logic                      o_margin_sw,
  output logic [14:0]               o_margin_lane_ctrl
);

  logic [31:0]  rdata_ff;
  logic [31:0]  nxt_rdata;
  logic [63:0]  serial_ff;
  logic [20:0]  pb_data_ff;
  logic [127:0] hlog_ff;
  logic [3:0]   eq16_flags_ff;
  logic [1:0]   margin_ready_ff;
  logic [15:0]  margin_lstat_ff;
  logic [7:0]   pb_select_ff;
  logic         pb_sys_alloc_ff;
  logic [2:0]   rid_group_ff;
  logic [1:0]   rid_en_ff;
  logic [3:0]   lane_err_ff;
  logic         eq16_req_ff;
  logic         margin_sw_ff;
  logic [7:0]   mg_payload_ff;
  logic [6:0]   mg_ctrl_lo_ff;
  pcx_pkg::pcx_access_t access;

  // Builds a capability header word from its next pointer and ID.
  function automatic logic [31:0] cap_hdr
  (
    input logic [11:0] next_ptr,
    input logic [15:0] cap_id
  );
    cap_hdr = {next_ptr, `PCX_CAP_VER, cap_id};
  endfunction : cap_hdr

  // True when the access targets the given word.
  function automatic logic hit
  (
    input pcx_pkg::pcx_addr_t addr,
    input pcx_pkg::pcx_addr_t off
  );
    hit = (addr == off);
  endfunction : hit

  always_comb
  begin
    if (i_write)
    begin
      access = pcx_pkg::PCX_ACC_WRITE;
    end
    else if (i_read)
    begin
      access = pcx_pkg::PCX_ACC_READ;
    end
    else
    begin
      access = pcx_pkg::PCX_ACC_NONE;
    end
  end

  // Snapshots of device state, zero while in reset.
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      serial_ff       <= 64'h0;
      pb_data_ff      <= 21'h0;
      hlog_ff         <= 128'h0;
      eq16_flags_ff   <= 4'h0;
      margin_ready_ff <= 2'h0;
      margin_lstat_ff <= 16'h0;
    end
    else
    begin
      serial_ff       <= i_serial_number;
      pb_data_ff      <= i_pb_data;
      hlog_ff         <= i_header_log;
      eq16_flags_ff   <= i_eq16_flags;
      margin_ready_ff <= i_margin_ready;
      margin_lstat_ff <= i_margin_lane_status;
    end
  end

  // Power budgeting settings.
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      pb_select_ff    <= 8'h0;
      pb_sys_alloc_ff <= `PCX_PB_SYSALLOC_RST;
    end
    else if (access == pcx_pkg::PCX_ACC_WRITE)
    begin
      if (hit(i_addr, `PCX_OFF_PB_SEL))
      begin
        pb_select_ff <= i_wdata[7:0];
      end
      else if (hit(i_addr, `PCX_OFF_PB_CAP))
      begin
        pb_sys_alloc_ff <= i_wdata[0];
      end
    end
  end

  // Routing-ID interpretation control.
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      rid_group_ff <= 3'h0;
      rid_en_ff    <= 2'h0;
    end
    else if (access == pcx_pkg::PCX_ACC_WRITE &&
             hit(i_addr, `PCX_OFF_RID_CTRL))
    begin
      rid_group_ff <= i_wdata[6:4];
      rid_en_ff    <= i_wdata[1:0];
    end
  end

  // Lane error bits: a hardware set wins over a software write.
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      lane_err_ff <= 4'h0;
    end
    else if (access == pcx_pkg::PCX_ACC_WRITE &&
             hit(i_addr, `PCX_OFF_LANE_ERR))
    begin
      lane_err_ff <= i_wdata[3:0] | i_lane_err_set;
    end
    else
    begin
      lane_err_ff <= lane_err_ff | i_lane_err_set;
    end
  end

  // Equalization request: a hardware set wins over a software write.
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      eq16_req_ff <= 1'h0;
    end
    else if (access == pcx_pkg::PCX_ACC_WRITE &&
             hit(i_addr, `PCX_OFF_P16_STAT))
    begin
      eq16_req_ff <= i_wdata[`PCX_P16_EQREQ_BIT] | i_eq16_req_set;
    end
    else
    begin
      eq16_req_ff <= eq16_req_ff | i_eq16_req_set;
    end
  end

  // Margining settings; lane control bit 7 is not stored.
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      margin_sw_ff  <= 1'h0;
      mg_payload_ff <= 8'h0;
      mg_ctrl_lo_ff <= 7'h0;
    end
    else if (access == pcx_pkg::PCX_ACC_WRITE)
    begin
      if (hit(i_addr, `PCX_OFF_MG_PCAP))
      begin
        margin_sw_ff <= i_wdata[0];
      end
      else if (hit(i_addr, `PCX_OFF_MG_LCTRL))
      begin
        mg_payload_ff <= i_wdata[15:8];
        mg_ctrl_lo_ff <= i_wdata[6:0];
      end
    end
  end

  // Read decode; unmapped and write-only cases read zero.
  always_comb
  begin
    nxt_rdata = 32'h0;
    if (access != pcx_pkg::PCX_ACC_READ)
    begin
      nxt_rdata = 32'h0;
    end
    else if (hit(i_addr, `PCX_OFF_HLOG0))
    begin
      nxt_rdata = hlog_ff[127:96];
    end
    else if (hit(i_addr, `PCX_OFF_HLOG1))
    begin
      nxt_rdata = hlog_ff[95:64];
    end
    else if (hit(i_addr, `PCX_OFF_HLOG2))
    begin
      nxt_rdata = hlog_ff[63:32];
    end
    else if (hit(i_addr, `PCX_OFF_HLOG3))
    begin
      nxt_rdata = hlog_ff[31:0];
    end
    else if (hit(i_addr, `PCX_OFF_SN_HDR))
    begin
      nxt_rdata = cap_hdr(`PCX_SN_NEXT, `PCX_SN_ID);
    end
    else if (hit(i_addr, `PCX_OFF_SN_LOW))
    begin
      nxt_rdata = serial_ff[31:0];
    end
    else if (hit(i_addr, `PCX_OFF_SN_HIGH))
    begin
      nxt_rdata = serial_ff[63:32];
    end
    else if (hit(i_addr, `PCX_OFF_PB_HDR))
    begin
      nxt_rdata = cap_hdr(`PCX_PB_NEXT, `PCX_POWER_BUDGET_CAP_HEADER);
    end
    else if (hit(i_addr, `PCX_OFF_PB_SEL))
    begin
      nxt_rdata = {24'h0, pb_select_ff};
    end
    else if (hit(i_addr, `PCX_OFF_PB_DATA))
    begin
      nxt_rdata = {11'h0, pb_data_ff};
    end
    else if (hit(i_addr, `PCX_OFF_PB_CAP))
    begin
      nxt_rdata = {31'h0, pb_sys_alloc_ff};
    end
    else if (hit(i_addr, `PCX_OFF_RID_HDR))
    begin
      nxt_rdata = cap_hdr(`PCX_RID_NEXT, `PCX_RID_ID);
    end
    else if (hit(i_addr, `PCX_OFF_RID_CAP))
    begin
      nxt_rdata = 32'h0;
    end
    else if (hit(i_addr, `PCX_OFF_RID_CTRL))
    begin
      nxt_rdata = {25'h0, rid_group_ff, 2'h0, rid_en_ff};
    end
    else if (hit(i_addr, `PCX_OFF_SL_HDR))
    begin
      nxt_rdata = cap_hdr(`PCX_SL_NEXT, `PCX_SL_ID);
    end
    else if (hit(i_addr, `PCX_OFF_LCTL3))
    begin
      nxt_rdata = 32'h0;
    end
    else if (hit(i_addr, `PCX_OFF_LANE_ERR))
    begin
      nxt_rdata = {28'h0, lane_err_ff};
    end
    else if (i_addr >= `PCX_OFF_LEQ_FIRST && i_addr <= `PCX_OFF_LEQ_LAST &&
             !i_addr[0])
    begin
      nxt_rdata = {17'h0, `PCX_LEQ_RX_HINT, `PCX_LEQ_TX_PRESET,
                   8'h0};
    end
    else if (hit(i_addr, `PCX_OFF_P16_HDR))
    begin
      nxt_rdata = cap_hdr(`PCX_P16_NEXT, `PCX_P16_ID);
    end
    else if (hit(i_addr, `PCX_OFF_P16_CAP) ||
             hit(i_addr, `PCX_OFF_P16_CTRL))
    begin
      nxt_rdata = 32'h0;
    end
    else if (hit(i_addr, `PCX_OFF_P16_STAT))
    begin
      nxt_rdata = {27'h0, eq16_req_ff, eq16_flags_ff};
    end
    else if (hit(i_addr, `PCX_OFF_MG_HDR))
    begin
      nxt_rdata = cap_hdr(`PCX_MG_NEXT, `PCX_MG_ID);
    end
    else if (hit(i_addr, `PCX_OFF_MG_PCAP))
    begin
      nxt_rdata = {31'h0, margin_sw_ff};
    end
    else if (hit(i_addr, `PCX_OFF_MG_PSTAT))
    begin
      nxt_rdata = {30'h0, margin_ready_ff};
    end
    else if (hit(i_addr, `PCX_OFF_MG_LCTRL))
    begin
      nxt_rdata = {16'h0, mg_payload_ff, 1'h0, mg_ctrl_lo_ff};
    end
    else if (hit(i_addr, `PCX_OFF_MG_LSTAT))
    begin
      nxt_rdata = {16'h0, margin_lstat_ff[15:8], 1'h0,
                   margin_lstat_ff[6:0]};
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      rdata_ff <= 32'h0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata            = rdata_ff;
  assign o_pb_select        = pb_select_ff;
  assign o_pb_sys_alloc     = pb_sys_alloc_ff;
  assign o_rid_func_group   = rid_group_ff;
  assign o_rid_group_en     = rid_en_ff;
  assign o_lane_err         = lane_err_ff;
  assign o_eq16_req         = eq16_req_ff;
  assign o_margin_sw        = margin_sw_ff;
  assign o_margin_lane_ctrl = {mg_payload_ff, mg_ctrl_lo_ff};

endmodule : pcx_ext_cap_regs

/* File: pcx_ext_cap_regs_props.sv */
`timescale 1ns/10ps
module pcx_ext_cap_regs_props
(
  // Clock, reset and register port.
  input wire logic               i_clock,
  input wire logic               i_resetn,
  input wire pcx_pkg::pcx_addr_t i_addr,
  input wire pcx_pkg::pcx_word_t i_wdata,
  input wire logic               i_write,
  input wire logic               i_read,
  input wire logic [31:0]        o_rdata,
  // Hardware sets and settings.
  input wire logic [3:0]         i_lane_err_set,
  input wire logic               i_eq16_req_set,
  input wire logic [7:0]         o_pb_select,
  input wire logic               o_pb_sys_alloc,
  input wire logic [3:0]         o_lane_err,
  input wire logic               o_eq16_req,
  input wire logic [14:0]        o_margin_lane_ctrl
);
  logic [31:0] wd_ff;

  always_ff @(posedge i_clock)
    wd_ff <= i_wdata;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  sequence rd_at(logic [11:0] a);
    i_read && i_addr == a;
  endsequence

  sequence wr_at(logic [11:0] a);
    i_write && i_addr == a;
  endsequence

  rdata_idle_a: assert property
    (!i_read |=> o_rdata == 32'h0) else $error("data not idle");
  sn_header_a: assert property
    (rd_at(12'h148) |=> o_rdata == 32'h1581_0003) else $error("bad header");
  sel_write_a: assert property
    (wr_at(12'h15C) |=> o_pb_select == wd_ff[7:0]) else $error("bad select");
  sel_hold_a: assert property
    (!(i_write && i_addr == 12'h15C) |=> $stable(o_pb_select))
    else $error("select moved");
  alloc_reset_a: assert property
    ($rose(i_resetn) |-> o_pb_sys_alloc) else $error("bad alloc reset");
  lane_ctrl_a: assert property
    (wr_at(12'h1C4) |=> o_margin_lane_ctrl == {wd_ff[15:8], wd_ff[6:0]})
    else $error("bad lane control");
  lane_err_a: assert property
    (|i_lane_err_set |=> (o_lane_err & $past(i_lane_err_set)) ==
      $past(i_lane_err_set)) else $error("lane error lost");
  eq_req_a: assert property
    (i_eq16_req_set |=> o_eq16_req) else $error("request lost");
endmodule : pcx_ext_cap_regs_props

bind pcx_ext_cap_regs pcx_ext_cap_regs_props pcx_ext_cap_regs_props_inst
(
  .i_clock, .i_resetn, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata,
  .i_lane_err_set, .i_eq16_req_set, .o_pb_select, .o_pb_sys_alloc,
  .o_lane_err, .o_eq16_req, .o_margin_lane_ctrl
);

/* File: testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic         i_clock;
  logic         i_resetn;
  logic [11:0]  i_addr;
  logic [31:0]  i_wdata;
  logic         i_write;
  logic         i_read;
  logic [31:0]  o_rdata;
  logic [63:0]  i_serial_number;
  logic [20:0]  i_pb_data;
  logic [127:0] i_header_log;
  logic [3:0]   i_lane_err_set;
  logic         i_eq16_req_set;
  logic [3:0]   i_eq16_flags;
  logic [1:0]   i_margin_ready;
  logic [15:0]  i_margin_lane_status;
  logic [7:0]   o_pb_select;
  logic         o_pb_sys_alloc;
  logic [2:0]   o_rid_func_group;
  logic [1:0]   o_rid_group_en;
  logic [3:0]   o_lane_err;
  logic         o_eq16_req;
  logic         o_margin_sw;
  logic [14:0]  o_margin_lane_ctrl;
  logic [34:0]  ctl, x;
  logic [31:0]  exp_q[$];
  logic [31:0]  d, e;
  logic [15:0]  r;
  logic         rd_d;
  int           num_errors;
  int           checks;
  localparam logic [34:0] rst_ctl = 35'h400_0000;
  logic [11:0]  wa[7] = '{12'h15C, 12'h164, 12'h16E, 12'h180, 12'h1A4,
    12'h1C0, 12'h1C4};
  logic [11:0]  ta[17] = '{12'h148, 12'h158, 12'h168, 12'h178, 12'h198,
    12'h1BC, 12'h17C, 12'h19C, 12'h1A0, 12'h184, 12'h186, 12'h188,
    12'h18A, 12'h16C, 12'h14C, 12'h144, 12'h185};
  logic [31:0]  te[17] = '{32'h1581_0003, 32'h1681_0004, 32'h1781_000E,
    32'h1981_0019, 32'h1BC1_0026, 32'h2241_0027, 32'h0, 32'h0, 32'h0,
    32'h7F00, 32'h7F00, 32'h7F00, 32'h7F00, 32'h0, 32'h0, 32'h0, 32'h0};

  initial
  begin
    i_clock = 1'h0;
    forever #4 i_clock = ~i_clock;
  end

  assign ctl = {o_pb_select, o_pb_sys_alloc, o_rid_func_group,
    o_rid_group_en, o_lane_err, o_eq16_req, o_margin_sw, o_margin_lane_ctrl};

  pcx_ext_cap_regs pcx_ext_cap_regs_inst
  (
    .i_clock, .i_resetn, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata,
    .i_serial_number, .i_pb_data, .i_header_log, .i_lane_err_set,
    .i_eq16_req_set, .i_eq16_flags, .i_margin_ready, .i_margin_lane_status,
    .o_pb_select, .o_pb_sys_alloc, .o_rid_func_group, .o_rid_group_en,
    .o_lane_err, .o_eq16_req, .o_margin_sw, .o_margin_lane_ctrl
  );

  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic cmp(logic [63:0] g, logic [63:0] w);
    checks++;
    if (g !== w)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, w);
    end
  endtask : cmp

  // One bus cycle; a read notes the data it expects.
  task automatic bus(logic w, logic rr, logic [11:0] a, logic [31:0] v);
    i_write <= w;
    i_read <= rr;
    i_addr <= a;
    i_wdata <= v;
    if (rr)
      exp_q.push_back(v);
    @(posedge i_clock);
  endtask : bus

  task automatic wr(logic [11:0] a, logic [31:0] v);
    bus(1'h1, 1'h0, a, v);
  endtask : wr

  task automatic rd(logic [11:0] a, logic [31:0] v);
    bus(1'h0, 1'h1, a, v);
  endtask : rd

  task automatic idle(int n);
    repeat (n) bus(1'h0, 1'h0, 12'h0, 32'h0);
  endtask : idle

  task automatic chk(logic [34:0] w);
    @(negedge i_clock);
    cmp(64'(ctl), 64'(w));
    @(posedge i_clock);
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  always @(posedge i_clock)
    rd_d <= i_read;

  always @(negedge i_clock)
    if (rd_d === 1'h1)
      cmp(64'(o_rdata), 64'(exp_q.pop_front()));
    else
      cmp(64'(o_rdata), 64'h0);

  initial
  begin
    repeat (2000) @(posedge i_clock);
    num_errors++;
    stop_test();
  end

  initial
  begin
    {i_write, i_read, i_addr, i_wdata, i_serial_number, i_pb_data} = '0;
    {i_header_log, i_lane_err_set, i_eq16_req_set, i_eq16_flags} = '0;
    {i_margin_ready, i_margin_lane_status, i_resetn} = '0;
    r = 16'hF22D;
    repeat (5) @(posedge i_clock);
    i_resetn <= 1'h1;
    @(posedge i_clock);
    chk(rst_ctl);
    foreach (ta[k])
      rd(ta[k], te[k]);
    $display("reset values tested");
    foreach (ta[k])
      wr(ta[k], 32'hFFFF_FFFF);
    foreach (ta[k])
      rd(ta[k], te[k]);
    idle(1);
    chk(rst_ctl);
    $display("read-only writes tested");
    repeat (4)
    begin
      r = lfsr(r);
      d[31:16] = r;
      r = lfsr(r);
      d[15:0] = r;
      foreach (wa[k])
        wr(wa[k], d);
      rd(12'h15C, {24'h0, d[7:0]});
      rd(12'h164, {31'h0, d[0]});
      rd(12'h16E, {25'h0, d[6:4], 2'h0, d[1:0]});
      rd(12'h180, {28'h0, d[3:0]});
      rd(12'h1A4, {27'h0, d[4], 4'h0});
      rd(12'h1C0, {31'h0, d[0]});
      rd(12'h1C4, {16'h0, d[15:8], 1'h0, d[6:0]});
      idle(1);
      x = {d[7:0], d[0], d[6:4], d[1:0], d[3:0], d[4], d[0], d[15:8], d[6:0]};
      chk(x);
    end
    $display("writable fields tested");
    r = lfsr(r);
    e = {r, ~r};
    i_serial_number <= {~e, e};
    i_pb_data <= e[20:0];
    i_header_log <= {e, ~e, d, ~d};
    i_eq16_flags <= e[3:0];
    i_margin_ready <= e[1:0];
    i_margin_lane_status <= e[15:0];
    idle(2);
    rd(12'h14C, e);
    rd(12'h150, ~e);
    rd(12'h160, {11'h0, e[20:0]});
    rd(12'h11C, e);
    rd(12'h120, ~e);
    rd(12'h124, d);
    rd(12'h128, ~d);
    rd(12'h1C2, {30'h0, e[1:0]});
    rd(12'h1C6, {16'h0, e[15:8], 1'h0, e[6:0]});
    rd(12'h1A4, {27'h0, d[4], e[3:0]});
    $display("status inputs tested");
    wr(12'h180, 32'h0);
    wr(12'h1A4, 32'h0);
    i_lane_err_set <= 4'hA;
    i_eq16_req_set <= 1'h1;
    idle(1);
    i_lane_err_set <= 4'h0;
    i_eq16_req_set <= 1'h0;
    rd(12'h180, 32'hA);
    rd(12'h1A4, {27'h1, e[3:0]});
    idle(1);
    i_lane_err_set <= 4'h1;
    i_eq16_req_set <= 1'h1;
    wr(12'h180, 32'h0);
    wr(12'h1A4, 32'h0);
    i_lane_err_set <= 4'h0;
    i_eq16_req_set <= 1'h0;
    rd(12'h180, 32'h1);
    rd(12'h1A4, {27'h1, e[3:0]});
    idle(1);
    $display("hardware sets tested");
    i_resetn <= 1'h0;
    idle(2);
    i_resetn <= 1'h1;
    idle(1);
    chk(rst_ctl);
    rd(12'h15C, 32'h0);
    idle(2);
    $display("second reset tested");
    stop_test();
  end
endmodule : testbench
